// ===== hdl/acdl_pkg.sv
package acdl_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // fixed-point format: seconds, signed, 32 fraction bits
    localparam int FIX_W = 64;
    localparam int FRAC_W = 32;
    typedef logic signed [FIX_W-1:0] acdl_fix_t;

    localparam int TAU_W = 5;
    localparam int POLL_W = 11;
    localparam int ADJ_SHIFT = 2;
    localparam int BUD_W = POLL_W - ADJ_SHIFT;
    localparam int DIV_CNT_W = 7;

    ////////////////////////////////////////////////////////////////////////////
    // clock and adjustment timing
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned ADJ_S = 4;
    localparam int unsigned ADJ_CYC = ADJ_S * CLK_HZ;

    ////////////////////////////////////////////////////////////////////////////
    // loop weights, as shift counts where a power of two
    localparam int KF_SHIFT = 22;
    localparam int KG_SHIFT = 8;
    localparam int KH_SHIFT = 13;
    localparam int KT_SHIFT = 14;
    localparam int KU_SHIFT = 6;
    localparam logic [TAU_W-1:0] KS_TAU = 5'h10;

    ////////////////////////////////////////////////////////////////////////////
    // reset values and divider step count
    localparam logic [TAU_W-1:0] TAU_RST = 5'h01;
    localparam logic [POLL_W-1:0] POLL_RST = 11'h040;
    localparam acdl_fix_t H_RST = 64'sh0000_0010_0000_0000;
    localparam logic [DIV_CNT_W-1:0] DIV_STEPS = 7'h40;

    typedef enum logic [2:0] {
        S_IDLE,
        S_FA,
        S_FB,
        S_G,
        S_TAU,
        S_H
    } acdl_state_t;

    typedef struct packed {
        acdl_fix_t freq_err;
        acdl_fix_t phase_err;
        acdl_fix_t compliance;
        logic [TAU_W-1:0] time_const;
        logic [POLL_W-1:0] poll_interval;
    } acdl_loop_t;

endpackage

// ===== hdl/acdl_tick_gen.sv
`timescale 1ns/1ns
`default_nettype none
module acdl_tick_gen #(
    parameter int unsigned CYC = acdl_pkg::ADJ_CYC
) (
    input wire logic ref_clk,
    input wire logic rst,
    output logic tick
);
    logic [31:0] cnt_ff;

    // one-cycle pulse every CYC clocks
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cnt_ff <= 32'h0;
            tick <= 1'b0;
        end else if (cnt_ff == CYC - 32'h1) begin
            cnt_ff <= 32'h0;
            tick <= 1'b1;
        end else begin
            cnt_ff <= cnt_ff + 32'h1;
            tick <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// ===== hdl/acdl_loop.sv
// Notes on behaviour
// - phase slews per tick, never stepped
// - reset zeroes all; tau 1, mu Ku, h Ks
// - f += mu*Vs/tau^2; g = Vs/tau
// - errors use previous tau and mu
// - tau = max(Ks-|h|,1); poll = Ku*tau
// - h += (Kt*tau*Vs - h)/Kh, last
// - residual loads g, decays each tick within the budget
// - ticks per interval = mu/sigma
// - each update processed exactly once, in order
// - powers of two done by shifts
// - sigma 4s, Kf 2^22, Kg 2^8, etc
`timescale 1ns/1ns
`default_nettype none
module acdl_loop #(
    parameter int unsigned ADJ_CYC = acdl_pkg::ADJ_CYC
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic upd_valid,
    input wire acdl_pkg::acdl_fix_t upd_offset,
    output logic upd_ready,
    output acdl_pkg::acdl_loop_t loop_st,
    output acdl_pkg::acdl_fix_t clk_phase,
    output logic tick_applied
);
    ////////////////////////////////////////////////////////////////////////////
    function automatic acdl_pkg::acdl_fix_t fix_abs(input acdl_pkg::acdl_fix_t x);
        fix_abs = x[acdl_pkg::FIX_W-1] ? -x : x;
    endfunction

    function automatic acdl_pkg::acdl_fix_t to_fix(input logic [acdl_pkg::POLL_W-1:0] p);
        to_fix = {{(acdl_pkg::FIX_W - acdl_pkg::POLL_W){1'b0}}, p};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    acdl_pkg::acdl_state_t state_ff, nxt_state;
    acdl_pkg::acdl_fix_t vs_ff, f_ff, g_ff, h_ff, res_ff, phase_ff;
    logic [acdl_pkg::TAU_W-1:0] tau_ff;
    logic [acdl_pkg::POLL_W-1:0] poll_ff;
    logic [acdl_pkg::BUD_W-1:0] budget_ff;
    logic tick_pend_ff, tick_do_ff;
    logic [acdl_pkg::FIX_W-1:0] dq_ff;
    logic [acdl_pkg::TAU_W:0] drem_ff, trial;
    logic [acdl_pkg::DIV_CNT_W-1:0] dcnt_ff;
    logic dneg_ff, div_done, div_start, tick, upd_fire, tick_take;
    acdl_pkg::acdl_fix_t div_arg, quo, hint, h_term;
    logic [acdl_pkg::TAU_W-1:0] tau_new;

    acdl_tick_gen #(.CYC(ADJ_CYC)) u_tick (
        .ref_clk(ref_clk),
        .rst(rst),
        .tick(tick)
    );

    // tick has priority; an update waits in idle until it is done
    assign tick_take = (state_ff == acdl_pkg::S_IDLE) && tick_pend_ff;
    assign upd_ready = (state_ff == acdl_pkg::S_IDLE) && !tick_pend_ff;
    assign upd_fire = upd_valid && upd_ready;
    assign div_done = (dcnt_ff == '0);
    assign quo = dneg_ff ? -acdl_pkg::acdl_fix_t'(dq_ff) : acdl_pkg::acdl_fix_t'(dq_ff);
    assign trial = {drem_ff[acdl_pkg::TAU_W-1:0], dq_ff[acdl_pkg::FIX_W-1]};

    assign loop_st.freq_err = f_ff;
    assign loop_st.phase_err = g_ff;
    assign loop_st.compliance = h_ff;
    assign loop_st.time_const = tau_ff;
    assign loop_st.poll_interval = poll_ff;
    assign clk_phase = phase_ff;
    assign tick_applied = tick_do_ff;

    ////////////////////////////////////////////////////////////////////////////
    // sequencer
    always_comb begin
        nxt_state = state_ff;
        div_start = 1'b0;
        div_arg = '0;
        case (state_ff)
            acdl_pkg::S_IDLE: begin
                if (upd_fire) begin
                    div_start = 1'b1;
                    div_arg = upd_offset * to_fix(poll_ff);
                    nxt_state = acdl_pkg::S_FA;
                end
            end
            acdl_pkg::S_FA: begin
                if (div_done) begin
                    div_start = 1'b1;
                    div_arg = quo;
                    nxt_state = acdl_pkg::S_FB;
                end
            end
            acdl_pkg::S_FB: begin
                if (div_done) begin
                    div_start = 1'b1;
                    div_arg = vs_ff;
                    nxt_state = acdl_pkg::S_G;
                end
            end
            acdl_pkg::S_G: begin
                if (div_done) begin
                    nxt_state = acdl_pkg::S_TAU;
                end
            end
            acdl_pkg::S_TAU: nxt_state = acdl_pkg::S_H;
            acdl_pkg::S_H: nxt_state = acdl_pkg::S_IDLE;
            default: nxt_state = acdl_pkg::S_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_ff <= acdl_pkg::S_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            vs_ff <= '0;
        end else if (upd_fire) begin
            vs_ff <= upd_offset;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // serial divider by the current time constant, truncating toward zero
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            dq_ff <= '0;
            drem_ff <= '0;
            dcnt_ff <= '0;
            dneg_ff <= 1'b0;
        end else if (div_start) begin
            dq_ff <= fix_abs(div_arg);
            drem_ff <= '0;
            dcnt_ff <= acdl_pkg::DIV_STEPS;
            dneg_ff <= div_arg[acdl_pkg::FIX_W-1];
        end else if (!div_done) begin
            if (trial >= {1'b0, tau_ff}) begin
                drem_ff <= trial - {1'b0, tau_ff};
                dq_ff <= {dq_ff[acdl_pkg::FIX_W-2:0], 1'b1};
            end else begin
                drem_ff <= trial;
                dq_ff <= {dq_ff[acdl_pkg::FIX_W-2:0], 1'b0};
            end
            dcnt_ff <= dcnt_ff - 7'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // loop variables
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            f_ff <= '0;
        end else if (state_ff == acdl_pkg::S_FB && div_done) begin
            f_ff <= f_ff + quo;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            g_ff <= '0;
        end else if (state_ff == acdl_pkg::S_G && div_done) begin
            g_ff <= quo;
        end
    end

    // integer part of |h|, compared with the compliance ceiling
    assign hint = fix_abs(h_ff) >>> acdl_pkg::FRAC_W;
    assign tau_new = (hint >= acdl_pkg::acdl_fix_t'(acdl_pkg::KS_TAU - 5'h01)) ?
        5'h01 : acdl_pkg::KS_TAU - hint[acdl_pkg::TAU_W-1:0];

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tau_ff <= acdl_pkg::TAU_RST;
            poll_ff <= acdl_pkg::POLL_RST;
        end else if (state_ff == acdl_pkg::S_TAU) begin
            tau_ff <= tau_new;
            poll_ff <= acdl_pkg::POLL_W'(tau_new) << acdl_pkg::KU_SHIFT;
        end
    end

    assign h_term = (vs_ff * to_fix(acdl_pkg::POLL_W'(tau_ff))) <<< acdl_pkg::KT_SHIFT;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            h_ff <= acdl_pkg::H_RST;
        end else if (state_ff == acdl_pkg::S_H) begin
            h_ff <= h_ff + ((h_term - h_ff) >>> acdl_pkg::KH_SHIFT);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // adjustment ticks
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tick_pend_ff <= 1'b0;
        end else if (tick) begin
            tick_pend_ff <= 1'b1; // set wins over the clear
        end else if (tick_take) begin
            tick_pend_ff <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            budget_ff <= '0;
        end else if (state_ff == acdl_pkg::S_H) begin
            budget_ff <= poll_ff[acdl_pkg::POLL_W-1:acdl_pkg::ADJ_SHIFT];
        end else if (tick_take && budget_ff != '0) begin
            budget_ff <= budget_ff - 9'h001;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tick_do_ff <= 1'b0;
        end else begin
            tick_do_ff <= tick_take && budget_ff != '0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            res_ff <= '0;
            phase_ff <= '0;
        end else if (state_ff == acdl_pkg::S_G && div_done) begin
            res_ff <= quo;
        end else if (tick_take && budget_ff != '0) begin
            phase_ff <= phase_ff + (res_ff >>> acdl_pkg::KG_SHIFT)
                + (f_ff >>> acdl_pkg::KF_SHIFT);
            res_ff <= res_ff - (res_ff >>> acdl_pkg::KG_SHIFT);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_reset_state: assert property ($fell(rst) |-> tau_ff == 5'h01 && poll_ff == 11'h040
        && f_ff == '0 && g_ff == '0 && h_ff == acdl_pkg::H_RST && phase_ff == '0)
        else $error("loop state wrong after reset");
    a_tick_phase: assert property (tick_take && budget_ff != '0 |=> phase_ff ==
        $past(phase_ff) + ($past(res_ff) >>> 8) + ($past(f_ff) >>> 22))
        else $error("tick phase increment wrong");
    a_phase_hold: assert property (!tick_do_ff |-> $stable(phase_ff) || $fell(rst))
        else $error("phase moved without a tick");
    a_tick_blocks: assert property (tick_pend_ff && state_ff == acdl_pkg::S_IDLE && !tick
        |=> !tick_pend_ff)
        else $error("pending tick not taken in idle");
    a_upd_once: assert property (upd_fire |=> !upd_ready [*8])
        else $error("update not processed atomically");
    a_upd_done: assert property (upd_fire |-> ##[190:200] state_ff == acdl_pkg::S_IDLE)
        else $error("update sequence length wrong");
    a_tau_range: assert property (tau_ff >= 5'h01 && tau_ff <= 5'h10)
        else $error("time constant out of range");
    a_poll_mult: assert property (poll_ff == {tau_ff, 6'h00})
        else $error("poll not Ku times tau");
    a_budget_load: assert property (state_ff == acdl_pkg::S_H |=> budget_ff ==
        $past(poll_ff) >> 2)
        else $error("tick budget wrong");
    a_freq_order: assert property ($changed(f_ff) |-> $past(state_ff) == acdl_pkg::S_FB)
        else $error("frequency error updated out of order");
    a_h_last: assert property ($changed(h_ff) |-> $past(state_ff) == acdl_pkg::S_H
        && state_ff == acdl_pkg::S_IDLE)
        else $error("compliance not updated last");

endmodule
`default_nettype wire

// ===== sim/acdl_offset_src.sv
`timescale 1ns/1ns
`default_nettype none
module acdl_offset_src (
    input wire logic ref_clk,
    input wire logic send,
    input wire acdl_pkg::acdl_fix_t send_offset,
    input wire logic upd_ready,
    output logic upd_valid,
    output acdl_pkg::acdl_fix_t upd_offset
);
    logic take_ff;
    initial begin
        upd_valid = 1'h0;
        upd_offset = '0;
        take_ff = 1'h0;
    end
    always @(posedge ref_clk) begin
        take_ff <= upd_valid && upd_ready;
    end
    // one offset at a time, held until taken; released offset keeps toggling
    always @(negedge ref_clk) begin
        if (take_ff || !upd_valid) begin
            upd_valid <= !take_ff && send;
            upd_offset <= (!take_ff && send) ? send_offset : ~upd_offset;
        end
    end
endmodule
`default_nettype wire

// ===== sim/acdl_loop_test.sv
`timescale 1ns/1ns
`default_nettype none
module acdl_loop_test;
    localparam int unsigned ADJ = 32;
    typedef struct packed {
        acdl_pkg::acdl_loop_t st;
        acdl_pkg::acdl_fix_t ph;
    } acdl_note_t;
    logic ref_clk = 1'h0;
    logic rst = 1'h1;
    logic send = 1'h0;
    acdl_pkg::acdl_fix_t send_offset = '0;
    logic upd_valid;
    logic upd_ready;
    logic tick_applied;
    acdl_pkg::acdl_fix_t upd_offset;
    acdl_pkg::acdl_fix_t clk_phase;
    acdl_pkg::acdl_loop_t loop_st;
    acdl_pkg::acdl_loop_t m;
    acdl_pkg::acdl_fix_t m_ph, m_res, ph_take;
    acdl_note_t notes[$];
    acdl_note_t nt;
    int fails = 0;
    int cmp_count = 0;
    int cycles = 0;
    int done_cnt = 0;
    int tick_cnt = 0;
    logic busy = 1'h0;
    integer seed = 32'hC811F96F;

    acdl_loop #(.ADJ_CYC(ADJ)) dut_u (
        .ref_clk(ref_clk), .rst(rst), .upd_valid(upd_valid), .upd_offset(upd_offset),
        .upd_ready(upd_ready), .loop_st(loop_st), .clk_phase(clk_phase),
        .tick_applied(tick_applied)
    );
    acdl_offset_src src_u (
        .ref_clk(ref_clk), .send(send), .send_offset(send_offset),
        .upd_ready(upd_ready), .upd_valid(upd_valid), .upd_offset(upd_offset)
    );

    always #20 ref_clk = ~ref_clk;

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_of_test();
        if (fails == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk_st(input acdl_pkg::acdl_loop_t s, input acdl_pkg::acdl_loop_t e);
        chk("freq_err", s.freq_err, e.freq_err);
        chk("phase_err", s.phase_err, e.phase_err);
        chk("time_const", 64'(s.time_const), 64'(e.time_const));
        chk("poll_interval", 64'(s.poll_interval), 64'(e.poll_interval));
        chk("compliance", s.compliance, e.compliance);
    endtask

    // watcher: phase seen at the take, loop state once the sequence is done
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles > 100000) begin
            fails++;
            end_of_test();
        end
        if (tick_applied === 1'h1) begin
            tick_cnt++;
        end
        if (rst) begin
            busy = 1'h0;
        end else if (!busy && upd_valid && upd_ready) begin
            busy = 1'h1;
            ph_take = clk_phase;
        end else if (busy && upd_ready) begin
            busy = 1'h0;
            done_cnt++;
            if (notes.size() > 0) begin
                nt = notes.pop_front();
                chk_st(loop_st, nt.st);
                chk("clk_phase", ph_take, nt.ph);
            end
        end
    end

    task automatic do_reset();
        @(negedge ref_clk);
        rst <= 1'h1;
        repeat (20) @(negedge ref_clk);
        rst <= 1'h0;
        notes.delete();
        m = '{freq_err: '0, phase_err: '0, compliance: 64'sh10_0000_0000,
              time_const: 5'h01, poll_interval: 11'h040};
        m_ph = '0;
        m_res = '0;
        @(negedge ref_clk);
        chk_st(loop_st, m);
        chk("clk_phase", clk_phase, '0);
        chk("tick_applied", 64'(tick_applied), '0);
        chk("upd_ready", 64'(upd_ready), 64'h1);
    endtask

    task automatic upd(input acdl_pkg::acdl_fix_t vs);
        acdl_pkg::acdl_fix_t t_o, mu_o, ip;
        int n0, k, nt0;
        t_o = $signed({59'h0, m.time_const});
        mu_o = $signed({53'h0, m.poll_interval});
        m.freq_err = m.freq_err + vs * mu_o / t_o / t_o;
        m.phase_err = vs / t_o;
        ip = (m.compliance < 64'sh0) ? -m.compliance : m.compliance;
        ip = ip >>> 32;
        m.time_const = (ip >= 64'shF) ? 5'h01 : 5'h10 - ip[4:0];
        m.poll_interval = {m.time_const, 6'h00};
        t_o = $signed({59'h0, m.time_const});
        m.compliance = m.compliance + ((((vs * t_o) <<< 14) - m.compliance) >>> 13);
        m_res = m.phase_err;
        notes.push_back('{st: m, ph: m_ph});
        repeat ($unsigned($random(seed)) % 16) @(negedge ref_clk);
        n0 = done_cnt;
        nt0 = tick_cnt;
        send <= 1'h1;
        send_offset <= vs;
        @(negedge ref_clk);
        send <= 1'h0;
        for (k = 0; k < 600 && done_cnt == n0; k++) @(negedge ref_clk);
        if (done_cnt == n0) begin
            fails++;
            end_of_test();
        end
        for (k = 0; k < 16 * m.time_const; k++) begin
            m_ph = m_ph + (m_res >>> 8) + (m.freq_err >>> 22);
            m_res = m_res - (m_res >>> 8);
        end
        repeat ((16 * m.time_const + 3) * ADJ) @(negedge ref_clk);
        chk("tick_count", 64'(tick_cnt - nt0), 64'(16 * m.time_const));
    endtask

    initial begin
        do_reset();
        upd(64'sh0);
        upd(-64'sh4_0000_0000);
        repeat (5) upd($signed({$random(seed), $random(seed)}) >>> 29);
        // reset in mid-sequence
        @(negedge ref_clk);
        send <= 1'h1;
        send_offset <= 64'sh1_0000_0000;
        @(negedge ref_clk);
        send <= 1'h0;
        repeat (60) @(negedge ref_clk);
        do_reset();
        upd(64'sh800_0000);
        upd(-64'sh1);
        upd(64'sh0);
        end_of_test();
    end
endmodule
`default_nettype wire
